// file: pkg/timer16_consts.svh
`ifndef TIMER16_CONSTS_SVH
`define TIMER16_CONSTS_SVH
// byte register offsets
`define OFS_CTRL2 4'h0
`define OFS_CTRL1 4'h1
`define OFS_STATUS 4'h2
`define OFS_CAP1_HI 4'h3
`define OFS_CAP1_LO 4'h4
`define OFS_CMP1_HI 4'h5
`define OFS_CMP1_LO 4'h6
`define OFS_CNT_HI 4'h7
`define OFS_CNT_LO 4'h8
`define OFS_ACNT_HI 4'h9
`define OFS_ACNT_LO 4'hA
`define OFS_CAP2_HI 4'hB
`define OFS_CAP2_LO 4'hC
`define OFS_CMP2_HI 4'hD
`define OFS_CMP2_LO 4'hE
// control_reg_one fields
`define C1_CAP_IRQ_EN 7
`define C1_CMP_IRQ_EN 6
`define C1_OVF_IRQ_EN 5
`define C1_FORCE2 4
`define C1_FORCE1 3
`define C1_LEVEL2 2
`define C1_CAP1_EDGE 1
`define C1_LEVEL1 0
// control_reg_two fields
`define C2_OUT1_EN 7
`define C2_OUT2_EN 6
`define C2_ONE_PULSE 5
`define C2_PWM 4
`define C2_CLK_HI 3
`define C2_CLK_LO 2
`define C2_CAP2_EDGE 1
`define C2_EXT_EDGE 0
// timer_status_reg fields
`define SR_CAP1 7
`define SR_CMP1 6
`define SR_OVF 5
`define SR_CAP2 4
`define SR_CMP2 3
// values
`define CNT_RESET 16'hFFFC
`define CNT_MAX 16'hFFFF
`define CMP_RESET 16'h8000
`define CLK_DIV4 2'h0
`define CLK_DIV2 2'h1
`define CLK_DIV8 2'h2
`define CLK_EXT 2'h3
`endif

// file: pkg/timer16_pkg.sv
package timer16_pkg;
  typedef struct packed {
    logic [15:0] cnt;
    logic [2:0] div;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic [1:0] cap_s1;
    logic [1:0] cap_s2;
    logic [1:0] cap_s3;
    logic [7:0] cr1;
    logic [7:0] cr2;
    logic overflow_flag;
    logic [1:0] capture_flag;
    logic [1:0] compare_flag;
    logic arm_ovf;
    logic [1:0] arm_cap;
    logic [1:0] arm_cmp;
    logic [1:0][15:0] icr;
    logic [1:0][15:0] ocr;
    logic [1:0] cap_block;
    logic [1:0] cmp_block;
    logic [7:0] low_latch;
    logic latch_valid;
    logic [1:0] pin;
    logic [7:0] rdata;
  } timer_state_t;
endpackage

// file: core/capture_compare_timer16.sv
// The placing of the registers and the plain strobed port were chosen for this implementation.
`include "timer16_consts.svh"
module capture_compare_timer16
  import timer16_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic halt,
  input wire logic irq_mask,
  input wire logic ext_clock_pin,
  input wire logic [1:0] capture_pin,
  output logic [1:0] compare_out_pin,
  output logic [1:0] compare_out_oe,
  output logic timer_irq
);

  localparam timer_state_t reset_state = '{
    cnt: `CNT_RESET,
    ocr: {`CMP_RESET, `CMP_RESET},
    default: '0
  };

  timer_state_t s;
  timer_state_t next_s;

  // compare target: slower clocks see the match one count late
  function automatic logic [15:0] match_value(input logic [15:0] ocr,
                                              input logic fast);
    match_value = fast ? ocr : 16'(ocr + 16'h0001);
  endfunction

  logic [1:0] clk_sel;
  logic fast_clk;
  logic ext_edge;
  logic tick;
  logic overflow_evt;
  logic [1:0] cap_edge;
  logic [1:0] cap_evt;
  logic [1:0] cmp_evt;
  logic wave_mode;
  logic [15:0] cnt_inc;
  logic acc_cnt_lo;
  logic acc_acnt_lo;
  logic [1:0] acc_cap_lo;
  logic [1:0] acc_cmp_lo;
  logic [1:0] level;
  logic [1:0] edge_sel;

  //////////////////////////////////////////////////////////////////////////
  // timer clock and events

  always_comb
  begin
    clk_sel = s.cr2[`C2_CLK_HI:`C2_CLK_LO];
    fast_clk = (clk_sel == `CLK_DIV2);
    wave_mode = s.cr2[`C2_ONE_PULSE] | s.cr2[`C2_PWM];
    level = {s.cr1[`C1_LEVEL2], s.cr1[`C1_LEVEL1]};
    edge_sel = {s.cr2[`C2_CAP2_EDGE], s.cr1[`C1_CAP1_EDGE]};
    // only the second and third stages feed edge logic
    ext_edge = s.cr2[`C2_EXT_EDGE] ? (s.ext_s2 & ~s.ext_s3)
                                   : (~s.ext_s2 & s.ext_s3);
    tick = 1'b0;
    if (!halt)
    begin
      case (clk_sel)
        `CLK_DIV2: tick = s.div[0];
        `CLK_DIV4: tick = &s.div[1:0];
        `CLK_DIV8: tick = &s.div;
        default: tick = ext_edge;
      endcase
    end
    cnt_inc = 16'(s.cnt + 16'h0001);
    overflow_evt = tick & (s.cnt == `CNT_MAX);
    for (int i = 0; i < 2; i++)
    begin
      cap_edge[i] = edge_sel[i] ? (s.cap_s2[i] & ~s.cap_s3[i])
                                : (~s.cap_s2[i] & s.cap_s3[i]);
      cmp_evt[i] = tick & ~s.cmp_block[i] &
                   (cnt_inc == match_value(s.ocr[i], fast_clk));
    end
    cap_evt[0] = cap_edge[0] & ~s.cap_block[0] & ~wave_mode;
    cap_evt[1] = cap_edge[1] & ~s.cap_block[1];
    acc_cnt_lo = (wr | rd) & (addr == `OFS_CNT_LO);
    acc_acnt_lo = (wr | rd) & (addr == `OFS_ACNT_LO);
    acc_cap_lo[0] = rd & (addr == `OFS_CAP1_LO);
    acc_cap_lo[1] = rd & (addr == `OFS_CAP2_LO);
    acc_cmp_lo[0] = (wr | rd) & (addr == `OFS_CMP1_LO);
    acc_cmp_lo[1] = (wr | rd) & (addr == `OFS_CMP2_LO);
  end

  //////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    next_s = s;
    next_s.ext_s1 = ext_clock_pin;
    next_s.ext_s2 = s.ext_s1;
    next_s.ext_s3 = s.ext_s2;
    next_s.cap_s1 = capture_pin;
    next_s.cap_s2 = s.cap_s1;
    next_s.cap_s3 = s.cap_s2;
    next_s.rdata = 8'h00;
    if (!halt)
      next_s.div = 3'(s.div + 3'h1);
    if (tick)
      next_s.cnt = cnt_inc;

    // clears from the second step of each pair; sets applied later win
    if (acc_cnt_lo && s.arm_ovf)
    begin
      next_s.overflow_flag = 1'b0;
      next_s.arm_ovf = 1'b0;
    end
    for (int i = 0; i < 2; i++)
    begin
      if (acc_cap_lo[i] && s.arm_cap[i])
      begin
        next_s.capture_flag[i] = 1'b0;
        next_s.arm_cap[i] = 1'b0;
      end
      if (acc_cmp_lo[i] && s.arm_cmp[i])
      begin
        next_s.compare_flag[i] = 1'b0;
        next_s.arm_cmp[i] = 1'b0;
      end
      if (acc_cap_lo[i])
        next_s.cap_block[i] = 1'b0;
    end

    // register writes
    if (wr)
    begin
      if (addr == `OFS_CTRL1)
      begin
        next_s.cr1 = wdata & 8'hE7;
        for (int i = 0; i < 2; i++)
        begin
          if (wdata[`C1_FORCE1 + i] && !wave_mode &&
              s.cr2[`C2_OUT1_EN - i])
            next_s.pin[i] = wdata[2 * i];
        end
      end
      else if (addr == `OFS_CTRL2)
        next_s.cr2 = wdata;
      else if (addr == `OFS_CMP1_HI)
      begin
        next_s.ocr[0][15:8] = wdata;
        next_s.cmp_block[0] = 1'b1;
      end
      else if (addr == `OFS_CMP1_LO)
      begin
        next_s.ocr[0][7:0] = wdata;
        next_s.cmp_block[0] = 1'b0;
      end
      else if (addr == `OFS_CMP2_HI)
      begin
        next_s.ocr[1][15:8] = wdata;
        next_s.cmp_block[1] = 1'b1;
      end
      else if (addr == `OFS_CMP2_LO)
      begin
        next_s.ocr[1][7:0] = wdata;
        next_s.cmp_block[1] = 1'b0;
      end
      else if (addr == `OFS_CNT_LO || addr == `OFS_ACNT_LO)
        next_s.cnt = `CNT_RESET;
    end

    // register reads, data stands in the following cycle
    if (rd)
    begin
      if (addr == `OFS_CTRL1)
        next_s.rdata = s.cr1;
      else if (addr == `OFS_CTRL2)
        next_s.rdata = s.cr2;
      else if (addr == `OFS_STATUS)
      begin
        next_s.rdata = {s.capture_flag[0], s.compare_flag[0],
                        s.overflow_flag, s.capture_flag[1],
                        s.compare_flag[1], 3'h0};
        // first step: arm only the flags seen set
        next_s.arm_ovf = s.arm_ovf | s.overflow_flag;
        next_s.arm_cap = s.arm_cap | s.capture_flag;
        next_s.arm_cmp = s.arm_cmp | s.compare_flag;
      end
      else if (addr == `OFS_CAP1_HI)
      begin
        next_s.rdata = s.icr[0][15:8];
        next_s.cap_block[0] = 1'b1;
      end
      else if (addr == `OFS_CAP1_LO)
        next_s.rdata = s.icr[0][7:0];
      else if (addr == `OFS_CAP2_HI)
      begin
        next_s.rdata = s.icr[1][15:8];
        next_s.cap_block[1] = 1'b1;
      end
      else if (addr == `OFS_CAP2_LO)
        next_s.rdata = s.icr[1][7:0];
      else if (addr == `OFS_CMP1_HI)
        next_s.rdata = s.ocr[0][15:8];
      else if (addr == `OFS_CMP1_LO)
        next_s.rdata = s.ocr[0][7:0];
      else if (addr == `OFS_CMP2_HI)
        next_s.rdata = s.ocr[1][15:8];
      else if (addr == `OFS_CMP2_LO)
        next_s.rdata = s.ocr[1][7:0];
      else if (addr == `OFS_CNT_HI || addr == `OFS_ACNT_HI)
      begin
        next_s.rdata = s.cnt[15:8];
        // repeated high reads keep the first snapshot
        if (!s.latch_valid)
        begin
          next_s.low_latch = s.cnt[7:0];
          next_s.latch_valid = 1'b1;
        end
      end
      else if (addr == `OFS_CNT_LO || addr == `OFS_ACNT_LO)
      begin
        next_s.rdata = s.latch_valid ? s.low_latch : s.cnt[7:0];
        next_s.latch_valid = 1'b0;
      end
    end

    // hardware events
    if (overflow_evt)
      next_s.overflow_flag = 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      if (cap_evt[i])
      begin
        next_s.icr[i] = s.cnt;
        next_s.capture_flag[i] = 1'b1;
      end
      if (cmp_evt[i])
      begin
        next_s.compare_flag[i] = 1'b1;
        if (s.cr2[`C2_OUT1_EN - i])
          next_s.pin[i] = level[i];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      s <= reset_state;
    else
      s <= next_s;
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  assign rdata = s.rdata;
  assign compare_out_pin = s.pin;
  assign compare_out_oe = {s.cr2[`C2_OUT2_EN], s.cr2[`C2_OUT1_EN]};
  // one request line; software sorts sources through the status flags
  assign timer_irq = ~irq_mask &
    ((s.overflow_flag & s.cr1[`C1_OVF_IRQ_EN]) |
     ((|s.capture_flag) & s.cr1[`C1_CAP_IRQ_EN]) |
     ((|s.compare_flag) & s.cr1[`C1_CMP_IRQ_EN]));

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence status_seen_ovf;
    rd && addr == `OFS_STATUS && s.overflow_flag;
  endsequence
  sequence count_low_touch;
    acc_cnt_lo && s.arm_ovf && !overflow_evt;
  endsequence

  a_overflow_flag_set: assert property (
    overflow_evt && !wr |=> s.overflow_flag && s.cnt == 16'h0000)
    else $error("overflow did not set flag");
  a_overflow_clear: assert property (
    status_seen_ovf ##[1:20] count_low_touch |=> !s.overflow_flag)
    else $error("overflow flag not cleared by pair");
  a_alt_keeps_flag: assert property (
    s.overflow_flag && acc_acnt_lo |=> s.overflow_flag)
    else $error("alternate low access cleared overflow");
  a_irq_gating: assert property (
    s.overflow_flag && s.cr1[`C1_OVF_IRQ_EN] |-> timer_irq == !irq_mask)
    else $error("overflow request gating wrong");
  a_halt_freeze: assert property (
    halt && !wr |=> $stable(s.cnt))
    else $error("counter moved in halt");
  a_capture_latch: assert property (
    cap_evt[1] |=> s.icr[1] == $past(s.cnt) && s.capture_flag[1])
    else $error("capture value wrong");
  a_capture_blocked: assert property (
    rd && addr == `OFS_CAP2_HI |=> !cap_evt[1] ##1 $stable(s.icr[1]))
    else $error("capture not blocked after high read");
  a_compare_flag: assert property (
    cmp_evt[0] && s.cr2[`C2_OUT1_EN] |=>
      s.compare_flag[0] && s.pin[0] == $past(s.cr1[`C1_LEVEL1]))
    else $error("compare match effects missing");
  a_compare_suspend: assert property (
    wr && addr == `OFS_CMP1_HI |=> !cmp_evt[0])
    else $error("compare ran while suspended");
  a_reload_value: assert property (
    wr && addr == `OFS_CNT_LO |=> s.cnt == `CNT_RESET)
    else $error("counter not reloaded");
  a_wave_no_cap1: assert property (
    wave_mode |-> !cap_evt[0])
    else $error("capture one active in wave mode");
  a_latch_take: assert property (
    rd && addr == `OFS_CNT_HI && !s.latch_valid |=>
      s.latch_valid && s.low_latch == $past(s.cnt[7:0]))
    else $error("count low byte not latched");
  a_latch_hold: assert property (
    s.latch_valid |=> $stable(s.low_latch))
    else $error("latched low byte changed");
  a_cap1_latch: assert property (
    cap_evt[0] |=> s.icr[0] == $past(s.cnt) && s.capture_flag[0])
    else $error("capture one value wrong");
  a_capture_clear: assert property (
    s.arm_cap[0] && acc_cap_lo[0] && !cap_evt[0] |=> !s.capture_flag[0])
    else $error("capture flag not cleared by pair");
  a_compare_clear: assert property (
    s.arm_cmp[0] && acc_cmp_lo[0] && !cmp_evt[0] |=> !s.compare_flag[0])
    else $error("compare flag not cleared by pair");
  a_out_disabled: assert property (
    cmp_evt[1] && !s.cr2[`C2_OUT2_EN] |=>
      s.compare_flag[1] && $stable(s.pin[1]))
    else $error("disabled output changed on match");
  a_force_quiet: assert property (
    wr && addr == `OFS_CTRL1 && !cmp_evt[0] && !s.compare_flag[0] |=>
      !s.compare_flag[0])
    else $error("force set the compare flag");
  a_force_level: assert property (
    wr && addr == `OFS_CTRL1 && wdata[`C1_FORCE1] && !wave_mode &&
      s.cr2[`C2_OUT1_EN] && !cmp_evt[0] |=>
      s.pin[0] == $past(wdata[`C1_LEVEL1]))
    else $error("force did not copy level");
  a_force_wave: assert property (
    wr && addr == `OFS_CTRL1 && wave_mode && !cmp_evt[0] |=>
      $stable(s.pin[0]))
    else $error("force acted in wave mode");
  a_fast_match: assert property (
    tick && fast_clk && !s.cmp_block[0] && cnt_inc == s.ocr[0] |->
      cmp_evt[0])
    else $error("divide by two match missed");
  a_slow_match: assert property (
    tick && !fast_clk && !s.cmp_block[0] && s.cnt == s.ocr[0] |->
      cmp_evt[0])
    else $error("slow clock match missed");
  a_ocr_sw_only: assert property (
    !wr |=> $stable(s.ocr))
    else $error("compare register changed by hardware");
  a_ext_edge_tick: assert property (
    clk_sel == `CLK_EXT && !halt && s.cr2[`C2_EXT_EDGE] &&
      $rose(s.ext_s2) |-> tick)
    else $error("external edge did not tick");

endmodule // capture_compare_timer16

// file: verif/pin_driver.sv
module pin_driver
(
  input wire logic clk,
  output logic ext_clock_pin,
  output logic [1:0] capture_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    ext_clock_pin = 1'b0;
    capture_pin = 2'b10;
  end

  ////////////////////////////////////////////////////////////////////////////
  // six cycles covers the input synchroniser and the edge spacing
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask

  // one rising and one falling edge on the clock pin
  task automatic ext_tick();
    @(posedge clk) ext_clock_pin <= 1'b1;
    settle();
    @(posedge clk) ext_clock_pin <= 1'b0;
    settle();
  endtask

  // pins stay tied to the timer, so every level change is seen
  task automatic cap(input int ch, input logic v);
    @(posedge clk) capture_pin[ch] <= v;
    settle();
  endtask
endmodule // pin_driver

// file: verif/tb_capture_compare_timer16.sv
`include "timer16_consts.svh"
module tb_capture_compare_timer16;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, resetn, wr, rd, halt, irq_mask, irq, ext;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic [1:0] cap, pin, oe;
  int errors, checks_done, cycles;

  pin_driver drv (.clk(clk), .ext_clock_pin(ext), .capture_pin(cap));

  capture_compare_timer16 dut (.clk(clk), .resetn(resetn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .halt(halt),
    .irq_mask(irq_mask), .ext_clock_pin(ext), .capture_pin(cap),
    .compare_out_pin(pin), .compare_out_oe(oe), .timer_irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // whole run is a few hundred cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // leaves time just after the answer edge, so pins are settled too
  task automatic rd_chk(input string name, input logic [3:0] a,
                        input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(name, {8'h00, rdata}, {8'h00, exp});
  endtask

  // prescaler and counter only move while halt is low, so n is exact
  task automatic run(input int n);
    @(posedge clk) halt <= 1'b0;
    repeat (n) @(posedge clk);
    halt <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    resetn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    halt = 1'b0;
    irq_mask = 1'b1;
    repeat (20) @(posedge clk);
    check("pin_in_reset", {14'h0, pin}, 16'h0000);
    resetn <= 1'b1;
    // external clock first, before the divided clock can wrap
    wr_reg(`OFS_CTRL2, 8'h8D);
    rd_chk("cmp1_hi", `OFS_CMP1_HI, 8'h80);
    rd_chk("cmp1_lo", `OFS_CMP1_LO, 8'h00);
    wr_reg(`OFS_CTRL1, 8'hE7);
    wr_reg(`OFS_CMP1_HI, 8'hFF);
    wr_reg(`OFS_CMP1_LO, 8'hFE);
    wr_reg(`OFS_CMP2_HI, 8'hFF);
    wr_reg(`OFS_CMP2_LO, 8'hFE);
    wr_reg(`OFS_CNT_LO, 8'h00);
    drv.ext_tick();
    drv.ext_tick();
    rd_chk("cnt_hi", `OFS_CNT_HI, 8'hFF);
    rd_chk("cnt_lo", `OFS_CNT_LO, 8'hFE);
    rd_chk("status_at_value", `OFS_STATUS, 8'h00);
    drv.ext_tick();
    rd_chk("status_match", `OFS_STATUS, 8'h48);
    check("pins_match", {14'h0, pin}, 16'h0001);
    check("oe", {14'h0, oe}, 16'h0001);
    check("irq_masked", {15'h0, irq}, 16'h0000);
    @(posedge clk) irq_mask <= 1'b0;
    #1;
    check("irq_open", {15'h0, irq}, 16'h0001);
    drv.cap(0, 1'b1);
    rd_chk("status_cap1", `OFS_STATUS, 8'hC8);
    rd_chk("cap1_hi", `OFS_CAP1_HI, 8'hFF);
    drv.ext_tick();
    // second edge lands while the channel is locked
    drv.cap(0, 1'b0);
    drv.cap(0, 1'b1);
    rd_chk("status_ovf", `OFS_STATUS, 8'hE8);
    rd_chk("cap1_lo", `OFS_CAP1_LO, 8'hFF);
    rd_chk("alt_lo", `OFS_ACNT_LO, 8'h00);
    rd_chk("status_alt", `OFS_STATUS, 8'h68);
    rd_chk("cnt_lo_clr", `OFS_CNT_LO, 8'h00);
    rd_chk("status_clr", `OFS_STATUS, 8'h48);
    drv.ext_tick();
    drv.cap(1, 1'b0);
    rd_chk("status_cap2", `OFS_STATUS, 8'h58);
    rd_chk("cap2_hi", `OFS_CAP2_HI, 8'h00);
    rd_chk("cap2_lo", `OFS_CAP2_LO, 8'h01);
    rd_chk("cmp1_lo_clr", `OFS_CMP1_LO, 8'hFE);
    wr_reg(`OFS_CTRL1, 8'hEE);
    rd_chk("status_force", `OFS_STATUS, 8'h08);
    check("pin_force", {14'h0, pin}, 16'h0000);
    check("irq_cmp2", {15'h0, irq}, 16'h0001);
    rd_chk("latch_hi", `OFS_CNT_HI, 8'h00);
    drv.ext_tick();
    rd_chk("latch_hi2", `OFS_CNT_HI, 8'h00);
    rd_chk("latch_lo", `OFS_CNT_LO, 8'h01);
    rd_chk("live_lo", `OFS_CNT_LO, 8'h02);
    // a clock edge while halted must not advance the count
    @(posedge clk) halt <= 1'b1;
    drv.ext_tick();
    @(posedge clk) halt <= 1'b0;
    rd_chk("halt_lo", `OFS_CNT_LO, 8'h02);
    // halted windows give an exact tick count for each divider
    @(posedge clk) halt <= 1'b1;
    wr_reg(`OFS_CTRL2, 8'h84);
    wr_reg(`OFS_CTRL1, 8'hE7);
    wr_reg(`OFS_CMP1_HI, 8'hFF);
    wr_reg(`OFS_CMP1_LO, 8'hFD);
    wr_reg(`OFS_CNT_LO, 8'h00);
    run(2);
    rd_chk("div2_cnt", `OFS_CNT_LO, 8'hFD);
    rd_chk("div2_match", `OFS_STATUS, 8'h48);
    check("div2_pin", {14'h0, pin}, 16'h0001);
    wr_reg(`OFS_CTRL2, 8'h80);
    wr_reg(`OFS_CMP1_LO, 8'hFD);
    wr_reg(`OFS_CNT_LO, 8'h00);
    run(4);
    rd_chk("div4_early", `OFS_STATUS, 8'h08);
    run(4);
    rd_chk("div4_match", `OFS_STATUS, 8'h48);
    rd_chk("div4_cnt", `OFS_CNT_LO, 8'hFE);
    wr_reg(`OFS_CTRL2, 8'h88);
    wr_reg(`OFS_CMP1_LO, 8'hFD);
    wr_reg(`OFS_CNT_LO, 8'h00);
    run(8);
    rd_chk("div8_cnt", `OFS_CNT_LO, 8'hFD);
    rd_chk("div8_status", `OFS_STATUS, 8'h08);
    // one pulse bit locks out capture one and the force bits
    wr_reg(`OFS_CTRL2, 8'hA0);
    drv.cap(0, 1'b0);
    drv.cap(0, 1'b1);
    rd_chk("wave_no_cap1", `OFS_STATUS, 8'h08);
    wr_reg(`OFS_CTRL1, 8'hEE);
    #1;
    check("wave_no_force", {14'h0, pin}, 16'h0001);
    rd_chk("unmapped", 4'hF, 8'h00);
    finish_test();
  end
endmodule // tb_capture_compare_timer16
